// >>> dbgmb_pkg.sv
package dbgmb_pkg;
  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NVM_AW = 12;
  localparam int NVM_DW = 16;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_MBOX = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_INT_STAT = 8'h0C;
  localparam logic [7:0] OFF_INT_CLR = 8'h10;
  localparam logic [7:0] OFF_INT_EN = 8'h14;
  localparam logic [7:0] OFF_NVM = 8'h18;

  // ==========================================================
  // field positions
  localparam int MB_DIRTY_BIT = 7;
  localparam int CTRL_TPD_BIT = 0;
  localparam int FUSE_DBG_BIT = 0;
  localparam int FUSE_TAP_BIT = 1;
  localparam int EV_W = 3;
  localparam int EV_TAKEN = 0;
  localparam int EV_REFUSED = 1;
  localparam int EV_ERASED = 2;

  // ==========================================================
  // reset values
  localparam logic [7:0] MBOX_RST = 8'h00;
  localparam logic [7:0] IO_RST = 8'h00;
  localparam logic [7:0] FUSE_RST = 8'h00;
  localparam logic [1:0] LOCK_RST = 2'h0;
  localparam logic [EV_W-1:0] INT_RST = 3'h0;

  // ==========================================================
  // test port instructions and programming operations
  localparam logic [3:0] IR_PROG = 4'h4;
  localparam logic [3:0] IR_MBOX = 4'h8;
  localparam logic [3:0] IR_DBGCTL = 4'h9;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] OP_FLASH_WR = 4'h1;
  localparam logic [3:0] OP_FLASH_RD = 4'h2;
  localparam logic [3:0] OP_EE_WR = 4'h3;
  localparam logic [3:0] OP_EE_RD = 4'h4;
  localparam logic [3:0] OP_FUSE_WR = 4'h5;
  localparam logic [3:0] OP_FUSE_RD = 4'h6;
  localparam logic [3:0] OP_LOCK_WR = 4'h7;
  localparam logic [3:0] OP_LOCK_RD = 4'h8;
  localparam logic [3:0] OP_ERASE = 4'h9;
  localparam logic [1:0] SEL_FLASH = 2'h0;
  localparam logic [1:0] SEL_EE = 2'h1;

  typedef enum logic [3:0] {
    S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR, S_EX2_DR,
    S_UPD_DR, S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PA_IR, S_EX2_IR, S_UPD_IR
  } dbgmb_tap_t;
endpackage

// >>> dbgmb_top.sv
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
// Summary of operation
// [R01] cpu write stores mailbox byte
// [R02] cpu write sets dirty flag
// [R03] read gives seven data bits, dirty top
// [R04] debugger clears dirty after taking byte
// [R05] mailbox reachable only when debug gated on
// [R06] test port needs fuse, disable bit clear
// [R07] locks block debug fuse until erase
// [R08] flash, eeprom, fuses, locks via test port
// [R09] debug works only with fuse, no locks
// [R10] reset clears mailbox byte and flag
module dbgmb_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dbgmb_pkg::ADDR_W-1:0] paddr,
  input wire logic [dbgmb_pkg::DATA_W-1:0] pwdata,
  output logic [dbgmb_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_en_n,
  input wire logic [7:0] fuse_init,
  input wire logic [1:0] lock_init,
  output logic [7:0] io_reg,
  output logic irq,
  output logic tap_enable,
  output logic ocd_active,
  output logic nvm_req,
  output logic [1:0] nvm_sel,
  output logic nvm_we,
  output logic nvm_erase,
  output logic [dbgmb_pkg::NVM_AW-1:0] nvm_addr,
  output logic [dbgmb_pkg::NVM_DW-1:0] nvm_wdata,
  input wire logic nvm_done,
  input wire logic [dbgmb_pkg::NVM_DW-1:0] nvm_rdata
);
  import dbgmb_pkg::*;

  // ==========================================================
  // link pin synchronisers
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic tck_prev;
  logic tck_rise;
  logic tck_fall;
  logic tms_s;
  logic tdi_s;

  // two stages, then edge detect on the second
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      tck_prev <= 1'b0;
    end else begin
      sync1 <= {tck, tms, tdi};
      sync2 <= sync1;
      tck_prev <= sync2[2];
    end
  end

  assign tck_rise = sync2[2] & ~tck_prev;
  assign tck_fall = ~sync2[2] & tck_prev;
  assign tms_s = sync2[1];
  assign tdi_s = sync2[0];

  // ==========================================================
  // test access port controller
  dbgmb_tap_t state, next_state;
  logic [3:0] ir, next_ir;
  logic [3:0] ir_sh, next_ir_sh;
  logic [31:0] dr, next_dr;
  logic next_tdo;
  logic next_tdo_en_n;
  logic dbg_en, next_dbg_en;
  logic clr_dirty;
  logic prog_go;
  logic dirty;
  logic [7:0] mbox;
  logic [NVM_DW-1:0] result;
  logic ocd_en;

  function automatic dbgmb_tap_t tap_step(input dbgmb_tap_t s, input logic m);
    case (s)
      S_TLR: tap_step = m ? S_TLR : S_RTI;
      S_RTI: tap_step = m ? S_SEL_DR : S_RTI;
      S_SEL_DR: tap_step = m ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: tap_step = m ? S_EX1_DR : S_SH_DR;
      S_SH_DR: tap_step = m ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: tap_step = m ? S_UPD_DR : S_PA_DR;
      S_PA_DR: tap_step = m ? S_EX2_DR : S_PA_DR;
      S_EX2_DR: tap_step = m ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: tap_step = m ? S_SEL_DR : S_RTI;
      S_SEL_IR: tap_step = m ? S_TLR : S_CAP_IR;
      S_CAP_IR: tap_step = m ? S_EX1_IR : S_SH_IR;
      S_SH_IR: tap_step = m ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: tap_step = m ? S_UPD_IR : S_PA_IR;
      S_PA_IR: tap_step = m ? S_EX2_IR : S_PA_IR;
      S_EX2_IR: tap_step = m ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: tap_step = m ? S_SEL_DR : S_RTI;
      default: tap_step = S_TLR;
    endcase
  endfunction

  // step on link rising edges, drive data out on falling edges
  always_comb begin
    next_state = state;
    next_ir = ir;
    next_ir_sh = ir_sh;
    next_dr = dr;
    next_tdo = tdo;
    next_tdo_en_n = tdo_en_n;
    next_dbg_en = dbg_en & ocd_en; // [R09]
    clr_dirty = 1'b0;
    prog_go = 1'b0;
    if (!tap_enable) begin
      // port held in reset while gated off
      next_state = S_TLR; // [R06]
      next_ir = IR_BYPASS;
      next_tdo_en_n = 1'b1;
    end else if (tck_rise) begin
      next_state = tap_step(state, tms_s);
      case (state)
        S_CAP_DR: begin
          case (ir)
            IR_MBOX: next_dr = {24'h000000, dirty, mbox[6:0]};
            IR_PROG: next_dr = {dr[31:16], result};
            IR_DBGCTL: next_dr = {31'h00000000, dbg_en};
            default: next_dr = 32'h00000000;
          endcase
        end
        S_SH_DR: begin
          case (ir)
            IR_MBOX: next_dr = {24'h000000, tdi_s, dr[7:1]};
            IR_PROG: next_dr = {tdi_s, dr[31:1]};
            default: next_dr = {31'h00000000, tdi_s};
          endcase
        end
        S_UPD_DR: begin
          case (ir)
            IR_MBOX: clr_dirty = 1'b1; // [R04]
            IR_DBGCTL: next_dbg_en = dr[0] & ocd_en; // [R05]
            IR_PROG: prog_go = 1'b1; // [R08]
            default: ;
          endcase
        end
        S_CAP_IR: next_ir_sh = IR_CAPTURE;
        S_SH_IR: next_ir_sh = {tdi_s, ir_sh[3:1]};
        S_UPD_IR: next_ir = ir_sh;
        default: ;
      endcase
      if (next_state == S_TLR) begin
        next_ir = IR_BYPASS;
      end
    end else if (tck_fall) begin
      next_tdo = (state == S_SH_IR) ? ir_sh[0] : dr[0];
      next_tdo_en_n = !(state == S_SH_IR || state == S_SH_DR);
    end
  end

  // test port state registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= S_TLR;
      ir <= IR_BYPASS;
      ir_sh <= 4'h0;
      dr <= 32'h00000000;
      tdo <= 1'b0;
      tdo_en_n <= 1'b1;
      dbg_en <= 1'b0;
    end else begin
      state <= next_state;
      ir <= next_ir;
      ir_sh <= next_ir_sh;
      dr <= next_dr;
      tdo <= next_tdo;
      tdo_en_n <= next_tdo_en_n;
      dbg_en <= next_dbg_en;
    end
  end

  // ==========================================================
  // registers, programming and interrupts
  logic [7:0] next_mbox;
  logic next_dirty;
  logic [7:0] next_io_reg;
  logic tpd, next_tpd;
  logic [EV_W-1:0] int_stat, next_int_stat;
  logic [EV_W-1:0] int_en, next_int_en;
  logic [EV_W-1:0] int_clr;
  logic [EV_W-1:0] ev;
  logic [7:0] fuse, next_fuse;
  logic [1:0] lock, next_lock;
  logic loaded, next_loaded;
  logic [NVM_DW-1:0] next_result;
  logic [DATA_W-1:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_nvm_req;
  logic [1:0] next_nvm_sel;
  logic next_nvm_we;
  logic next_nvm_erase;
  logic [NVM_AW-1:0] next_nvm_addr;
  logic [NVM_DW-1:0] next_nvm_wdata;
  logic access;
  logic mbox_sel;
  logic mbox_wr;
  logic [3:0] op;
  logic [7:0] nf;

  assign ocd_en = fuse[FUSE_DBG_BIT] & ~|lock; // [R09]
  assign mbox_sel = ocd_en & dbg_en; // [R05]
  assign access = psel & penable & ~pready;
  assign mbox_wr = access & pwrite & (paddr == OFF_MBOX) & mbox_sel;
  assign op = dr[31:28];

  // bus decode, debugger requests, event collection
  always_comb begin
    next_mbox = mbox;
    next_dirty = dirty;
    next_io_reg = io_reg;
    next_tpd = tpd;
    next_int_en = int_en;
    next_fuse = fuse;
    next_lock = lock;
    next_loaded = 1'b1;
    next_result = result;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_nvm_req = 1'b0;
    next_nvm_sel = nvm_sel;
    next_nvm_we = nvm_we;
    next_nvm_erase = 1'b0;
    next_nvm_addr = nvm_addr;
    next_nvm_wdata = nvm_wdata;
    int_clr = '0;
    ev = '0;
    nf = dr[7:0];
    // fuses and locks picked up once after reset
    if (!loaded) begin
      next_fuse = fuse_init;
      next_lock = lock_init;
    end
    // debugger takes the byte; a same-cycle cpu write keeps it set
    if (clr_dirty && dirty) begin
      next_dirty = 1'b0; // [R04]
      ev[EV_TAKEN] = 1'b1;
    end
    // apb access, answered one cycle after the access phase opens
    if (access) begin
      next_pready = 1'b1;
      if (pwrite) begin
        case (paddr)
          OFF_MBOX: begin
            if (mbox_sel) begin
              next_mbox = pwdata[7:0]; // [R01]
              next_dirty = 1'b1; // [R02]
            end else begin
              next_io_reg = pwdata[7:0]; // [R05]
            end
          end
          OFF_CTRL: next_tpd = pwdata[CTRL_TPD_BIT];
          OFF_INT_CLR: int_clr = pwdata[EV_W-1:0];
          OFF_INT_EN: next_int_en = pwdata[EV_W-1:0];
          OFF_STAT, OFF_INT_STAT, OFF_NVM: ;
          default: next_pslverr = 1'b1;
        endcase
      end else begin
        next_prdata = '0;
        case (paddr)
          OFF_MBOX: begin
            if (mbox_sel) begin
              next_prdata[7:0] = {dirty, mbox[6:0]}; // [R03]
            end else begin
              next_prdata[7:0] = io_reg;
            end
          end
          OFF_CTRL: next_prdata[CTRL_TPD_BIT] = tpd;
          OFF_STAT: next_prdata[3:0] = {|lock, mbox_sel, ocd_en, tap_enable};
          OFF_INT_STAT: next_prdata[EV_W-1:0] = int_stat;
          OFF_INT_EN: next_prdata[EV_W-1:0] = int_en;
          OFF_NVM: next_prdata[9:0] = {lock, fuse};
          OFF_INT_CLR: ;
          default: next_pslverr = 1'b1;
        endcase
      end
    end
    // programming commands from the test port
    if (prog_go) begin
      case (op)
        OP_FLASH_WR, OP_FLASH_RD, OP_EE_WR, OP_EE_RD: begin
          next_nvm_req = 1'b1; // [R08]
          next_nvm_sel = (op == OP_EE_WR || op == OP_EE_RD) ? SEL_EE : SEL_FLASH;
          next_nvm_we = (op == OP_FLASH_WR || op == OP_EE_WR);
          next_nvm_addr = dr[27:16];
          next_nvm_wdata = dr[15:0];
        end
        OP_FUSE_WR: begin
          if (|lock && nf[FUSE_DBG_BIT] && !fuse[FUSE_DBG_BIT]) begin
            nf[FUSE_DBG_BIT] = 1'b0; // [R07]
            ev[EV_REFUSED] = 1'b1;
          end
          next_fuse = nf; // [R08]
        end
        OP_FUSE_RD: next_result = {8'h00, fuse};
        OP_LOCK_WR: next_lock = lock | dr[1:0];
        OP_LOCK_RD: next_result = {14'h0000, lock};
        OP_ERASE: begin
          next_lock = LOCK_RST; // [R07]
          next_nvm_erase = 1'b1;
          ev[EV_ERASED] = 1'b1;
        end
        default: ;
      endcase
    end
    if (nvm_done) begin
      next_result = nvm_rdata;
    end
    // sticky events, set wins over clear
    next_int_stat = (int_stat & ~int_clr) | ev;
  end

  // register bank
  always_ff @(posedge clock) begin
    if (rst) begin
      mbox <= MBOX_RST; // [R10]
      dirty <= 1'b0; // [R10]
      io_reg <= IO_RST;
      tpd <= 1'b0;
      int_stat <= INT_RST;
      int_en <= INT_RST;
      fuse <= FUSE_RST;
      lock <= LOCK_RST;
      loaded <= 1'b0;
      result <= '0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      tap_enable <= 1'b0;
      ocd_active <= 1'b0;
      nvm_req <= 1'b0;
      nvm_sel <= SEL_FLASH;
      nvm_we <= 1'b0;
      nvm_erase <= 1'b0;
      nvm_addr <= '0;
      nvm_wdata <= '0;
    end else begin
      mbox <= next_mbox;
      dirty <= next_dirty;
      io_reg <= next_io_reg;
      tpd <= next_tpd;
      int_stat <= next_int_stat;
      int_en <= next_int_en;
      fuse <= next_fuse;
      lock <= next_lock;
      loaded <= next_loaded;
      result <= next_result;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= |(int_stat & int_en);
      tap_enable <= fuse[FUSE_TAP_BIT] & ~tpd; // [R06]
      ocd_active <= ocd_en; // [R09]
      nvm_req <= next_nvm_req;
      nvm_sel <= next_nvm_sel;
      nvm_we <= next_nvm_we;
      nvm_erase <= next_nvm_erase;
      nvm_addr <= next_nvm_addr;
      nvm_wdata <= next_nvm_wdata;
    end
  end
endmodule

// >>> dbgmb_properties.sv
`timescale 1ns/1ps
// ==========================================
// bus, gate and pulse checks at the top ports
module dbgmb_properties
  import dbgmb_pkg::*;
(
  input logic clock,
  input logic rst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [dbgmb_pkg::ADDR_W-1:0] paddr,
  input logic [dbgmb_pkg::DATA_W-1:0] pwdata,
  input logic [dbgmb_pkg::DATA_W-1:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic tdo_en_n,
  input logic irq,
  input logic tap_enable,
  input logic ocd_active,
  input logic nvm_req,
  input logic nvm_erase
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic acc;
  logic done;
  // access phase waiting, and access phase answered
  assign acc = psel && penable && !pready;
  assign done = psel && penable && pready;
  property p_one_wait;
    acc && paddr[1:0] == 2'h0 && paddr <= OFF_NVM |=> pready && !pslverr;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("mapped access not answered after one wait");
  property p_unmapped;
    acc && paddr >= 8'h1C |=> pready && pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access without error");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("ready longer than one cycle");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("error without ready");
  property p_tpd;
    done && pwrite && paddr == OFF_CTRL && pwdata[CTRL_TPD_BIT] |-> ##[1:3] !tap_enable;
  endproperty
  a_tpd: assert property (p_tpd)
    else $error("test port stays enabled after disable bit set");
  property p_stat;
    done && !pwrite && paddr == OFF_STAT |-> prdata[0] == tap_enable && prdata[1] == ocd_active;
  endproperty
  a_stat: assert property (p_stat)
    else $error("status bits disagree with enable outputs");
  property p_lock;
    done && !pwrite && paddr == OFF_NVM && prdata[9:8] != 2'h0 |-> !ocd_active;
  endproperty
  a_lock: assert property (p_lock)
    else $error("debug active with a lock bit set");
  property p_irq_off;
    done && pwrite && paddr == OFF_INT_EN && pwdata[EV_W-1:0] == 3'h0 |-> ##[1:3] !irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt stays high with all enables off");
  property p_tap_idle;
    !tap_enable [*3] |-> tdo_en_n;
  endproperty
  a_tap_idle: assert property (p_tap_idle)
    else $error("test data driven while port disabled");
  property p_nvm_pulse;
    nvm_req || nvm_erase |=> !nvm_req && !nvm_erase;
  endproperty
  a_nvm_pulse: assert property (p_nvm_pulse)
    else $error("memory request longer than one cycle");
  c_err: cover property (pslverr);
  c_erase: cover property (nvm_erase);
  c_irq: cover property ($rose(irq));
endmodule
bind dbgmb_top dbgmb_properties i_dbgmb_properties (.clock, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .tdo_en_n, .irq, .tap_enable, .ocd_active,
  .nvm_req, .nvm_erase);

// >>> dbgmb_debugger.sv
`timescale 1ns/1ps
// ==========================================
// debugger model on the test port pins
module dbgmb_debugger
  import dbgmb_pkg::*;
(
  output logic tck,
  output logic tms,
  output logic tdi,
  input logic tdo
);
  logic [31:0] q;
  // link clock stands low between frames
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end
  // one 320 ns period, tdo taken at the rising edge
  // link edges fall mid-cycle of the system clock, never on its rising edge
  task automatic step(input logic m, input logic i);
    tms = m;
    tdi = i;
    #140 tck = 1'h1;
    q = {tdo, q[31:1]};
    #160 tck = 1'h0;
    #20;
  endtask
  // tms sequence lsb first, tdi toggling so it never rests
  task automatic walk(input logic [5:0] seq, input int n);
    for (int k = 0; k < n; k++) step(seq[k], ~tdi);
  endtask
  task automatic reset_tap;
    walk(6'h1F, 6);
  endtask
  // ir or dr scan from idle back to idle, lsb first
  task automatic scan(input logic ir, input logic [31:0] d, input int n, output logic [31:0] r);
    walk(ir ? 6'h03 : 6'h01, ir ? 4 : 3);
    for (int k = 0; k < n; k++) step(k == n - 1, d[k]);
    // result taken before the exit steps push more samples in
    r = q >> (32 - n);
    walk(6'h01, 2);
  endtask
  // debugger grants cpu access to the mailbox
  task automatic open_mbox;
    logic [31:0] r;
    scan(1'h1, {28'h0, IR_DBGCTL}, 4, r);
    scan(1'h0, 32'h1, 1, r);
  endtask
  // take the byte; update clears the dirty flag
  task automatic take(output logic [7:0] b);
    logic [31:0] r;
    scan(1'h1, {28'h0, IR_MBOX}, 4, r);
    scan(1'h0, 32'h0, 8, r);
    b = r[7:0];
  endtask
  // one programming operation
  task automatic prog(input logic [3:0] op, input logic [11:0] a, input logic [15:0] d,
                      output logic [31:0] r);
    scan(1'h1, {28'h0, IR_PROG}, 4, r);
    scan(1'h0, {op, a, d}, 32, r);
  endtask
endmodule

// >>> dbgmb_top_tb.sv
`timescale 1ns/1ps
// ==========================================
// bench for the mailbox and test port gate
module dbgmb_top_tb;
  import dbgmb_pkg::*;
  logic clock = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00, io_reg;
  logic [31:0] pwdata = 32'h0, prdata, nvm_last;
  logic pready, pslverr, tck, tms, tdi, tdo, tdo_en_n, irq, tap_enable, ocd_active;
  logic nvm_req, nvm_we, nvm_erase, nvm_done = 1'h0, err;
  logic [1:0] nvm_sel;
  logic [11:0] nvm_addr;
  logic [15:0] nvm_wdata, nvm_rdata = 16'hC3A5;
  int fails = 0, checked = 0, erases = 0;
  dbgmb_top i_dbgmb_top (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tck, .tms, .tdi, .tdo, .tdo_en_n, .fuse_init(8'h03),
    .lock_init(2'h0), .io_reg, .irq, .tap_enable, .ocd_active, .nvm_req, .nvm_sel, .nvm_we,
    .nvm_erase, .nvm_addr, .nvm_wdata, .nvm_done, .nvm_rdata);
  dbgmb_debugger i_dbgmb_debugger (.tck, .tms, .tdi, .tdo);
  always #20 clock = ~clock;
  // memory side answers a cycle later and logs requests
  always @(posedge clock) begin
    nvm_done <= nvm_req;
    if (nvm_req) nvm_last <= {1'h0, nvm_sel, nvm_we, nvm_addr, nvm_wdata};
    if (nvm_erase) erases <= erases + 1;
  end
  // ==========================================
  // shared tasks
  task automatic end_sim;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) begin
      fails++;
      end_sim;
    end
    r = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'h0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'h1, a, d, r);
  endtask
  // ==========================================
  // scenarios
  task automatic t_gate;
    rd(OFF_MBOX, 32'h0);
    rd(OFF_STAT, 32'h3);
    wr(OFF_MBOX, 32'h11);
    chk(io_reg, 32'h11);
    i_dbgmb_debugger.reset_tap;
    i_dbgmb_debugger.open_mbox;
    rd(OFF_STAT, 32'h7);
    rd(OFF_MBOX, 32'h0);
    wr(OFF_MBOX, 32'h5A);
    rd(OFF_MBOX, 32'hDA);
    chk(io_reg, 32'h11);
  endtask
  task automatic t_take;
    logic [7:0] b;
    wr(OFF_INT_EN, 32'h1);
    i_dbgmb_debugger.take(b);
    chk(b, 32'hDA);
    rd(OFF_MBOX, 32'h5A);
    chk(irq, 32'h1);
    wr(OFF_INT_EN, 32'h0);
    chk(irq, 32'h0);
    wr(OFF_INT_CLR, 32'h1);
    rd(OFF_INT_STAT, 32'h0);
    wr(OFF_CTRL, 32'h1);
    chk(tap_enable, 32'h0);
    wr(OFF_CTRL, 32'h0);
    chk(tap_enable, 32'h1);
    i_dbgmb_debugger.reset_tap;
  endtask
  task automatic t_prog;
    logic [31:0] r;
    i_dbgmb_debugger.prog(OP_LOCK_WR, 12'h000, 16'h0001, r);
    rd(OFF_STAT, 32'h9);
    i_dbgmb_debugger.prog(OP_FUSE_WR, 12'h000, 16'h0002, r);
    i_dbgmb_debugger.prog(OP_FUSE_WR, 12'h000, 16'h0003, r);
    rd(OFF_NVM, 32'h102);
    rd(OFF_INT_STAT, 32'h2);
    i_dbgmb_debugger.prog(OP_ERASE, 12'h000, 16'h0000, r);
    chk(erases, 32'h1);
    i_dbgmb_debugger.prog(OP_FUSE_WR, 12'h000, 16'h0003, r);
    rd(OFF_NVM, 32'h003);
    rd(OFF_STAT, 32'h3);
    i_dbgmb_debugger.prog(OP_FLASH_WR, 12'h123, 16'hBEEF, r);
    chk(nvm_last, {1'h0, SEL_FLASH, 1'h1, 12'h123, 16'hBEEF});
    i_dbgmb_debugger.prog(OP_EE_RD, 12'h045, 16'h0000, r);
    chk(nvm_last[30:16], {SEL_EE, 1'h0, 12'h045});
    i_dbgmb_debugger.prog(OP_FUSE_RD, 12'h000, 16'h0000, r);
    chk(r[15:0], nvm_rdata);
    i_dbgmb_debugger.prog(OP_LOCK_RD, 12'h000, 16'h0000, r);
    chk(r[15:0], 32'h3);
    apb(1'h0, 8'h1C, 32'h0, r);
    chk(err, 32'h1);
    wr(OFF_STAT, 32'hF);
    rd(OFF_STAT, 32'h3);
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    t_gate;
    t_take;
    t_prog;
    end_sim;
  end
  initial begin
    #1000000;
    fails++;
    end_sim;
  end
endmodule
